// File: inc/ser_pkg.sv
package ser_pkg;

    // Register addresses on the serial link.
    localparam logic [6:0] SER_ADDR_SW_DATA = 7'h01;
    localparam logic [6:0] SER_ADDR_ERR_CONFIG = 7'h02;
    localparam logic [6:0] SER_ADDR_ERROR_FLAGS = 7'h03;
    localparam logic [6:0] SER_ADDR_BURST = 7'h05;
    localparam logic [6:0] SER_ADDR_SOFT_RESET = 7'h0b;

    // Special commands and key values.
    localparam logic [15:0] SER_CLEAR_CMD = 16'h6ca9;
    localparam logic [7:0] SER_KEY_FIRST = 8'ha3;
    localparam logic [7:0] SER_KEY_SECOND = 8'h05;

    // Reset values.
    localparam logic [7:0] SER_ERROR_FLAGS_RST = 8'h00;
    localparam logic SER_BURST_RST = 1'b0;

    // Field positions.
    localparam int SER_FLAG_CRC_BIT = 0;
    localparam int SER_FLAG_SCLK_BIT = 1;
    localparam int SER_FLAG_RW_BIT = 2;
    localparam int SER_BURST_BIT = 0;

    // Frame lengths in serial clock cycles.
    localparam logic [4:0] SER_FRAME_BITS_PLAIN = 5'h10;
    localparam logic [4:0] SER_FRAME_BITS_CRC = 5'h18;
    localparam logic [4:0] SER_ADDR_BITS_DONE = 5'h08;
    localparam logic [4:0] SER_BITCNT_RST = 5'h00;

    typedef struct packed {
        logic rd;
        logic [6:0] addr;
        logic [7:0] data;
    } ser_cmd_s;

    typedef struct packed {
        logic rw;
        logic sclk;
        logic crc;
    } ser_err_en_s;

    typedef enum logic [1:0] {
        SER_KEY_IDLE = 2'b01,
        SER_KEY_ARMED = 2'b10
    } ser_key_e;

endpackage

// File: rtl/ser_regs.sv
`timescale 1ns/1ps
// Function
// - Command 0x6CA9 clears every error flag.
// - The clear command never raises the invalid address flag.
// - With CRC enabled, the clear happens only when its CRC byte matches.
// - A read of a missing address sets flag bit 2.
// - A write to a missing or read-only address sets flag bit 2.
// - A frame with the wrong serial clock count sets flag bit 1.
// - A write whose CRC check fails sets flag bit 0.
// - Error flags: read-only at 0x03, reset 0x00, bits 7 to 3 read zero.
// - In burst mode several commands may share one select assertion.
// - Burst enable is bit 0 of register 0x05, read/write, reset disabled.
// - Software reset only after writes 0xA3 then 0x05 to register 0x0B.
// - A completed key sequence returns all registers to defaults.
// - Each error check reports only while its own enable is set.
// - Clock count expects 16, or 24 with CRC, times frames in burst.
// - With CRC each frame is 24 bits: command then CRC byte.
module ser_regs
    import ser_pkg::*;
#(
    parameter logic [7:0] CRC_POLY = 8'h07,
    parameter logic [7:0] CRC_INIT = 8'h00
) (
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic link_sclk,
    input wire logic cs_n,
    input wire logic mosi,
    output logic sdo,
    output logic sdo_oe,
    input wire ser_pkg::ser_err_en_s err_en,
    output logic [7:0] error_flags,
    output logic burst_en,
    output logic soft_rst
);
    import ser_pkg::*;

    // Link domain: runs only while the host drives the serial clock, in frames or with select high.
    logic crc_en_s1_r;
    logic crc_en_s2_r;
    logic fresh_r;
    logic [4:0] bitcnt_r;
    logic [23:0] shift_r;
    logic [23:0] frame_word_r;
    logic frame_tog_r;
    logic [7:0] tx_r;
    logic sdo_r;
    logic sdo_oe_r;

    // Core domain.
    logic cs_s1_r;
    logic cs_s2_r;
    logic cs_q_r;
    logic tog_s1_r;
    logic tog_s2_r;
    logic tog_q_r;
    logic [1:0] frames_r;
    logic [7:0] flags_r;
    logic [7:0] flags_nxt;
    logic burst_r;
    logic burst_nxt;
    ser_key_e key_r;
    ser_key_e key_nxt;
    logic soft_rst_r;

    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 15; i >= 0; i--) begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction

    // ---------------- Link domain ----------------

    wire logic [4:0] frame_len = crc_en_s2_r ? SER_FRAME_BITS_CRC : SER_FRAME_BITS_PLAIN;
    wire logic [4:0] bit_cur = fresh_r ? SER_BITCNT_RST : bitcnt_r;
    wire logic [4:0] bit_inc = bit_cur + 5'h01;
    wire logic frame_done = (bit_inc == frame_len);
    wire logic [23:0] shift_in = {shift_r[22:0], mosi};

    // The frame start marker is preset by the idle select line, so the bit
    // counter restarts on the first edge without needing a clock while idle.
    always_ff @(posedge link_sclk or posedge cs_n) begin
        if (cs_n) begin
            fresh_r <= 1'b1;
        end else begin
            fresh_r <= 1'b0;
        end
    end

    always_ff @(posedge link_sclk or negedge rst_n) begin
        if (!rst_n) begin
            crc_en_s1_r <= 1'b0;
            crc_en_s2_r <= 1'b0;
        end else begin
            crc_en_s1_r <= err_en.crc;
            crc_en_s2_r <= crc_en_s1_r;
        end
    end

    // Bits beyond a whole frame keep counting, so a short tail stays visible
    // in the counter after select rises.
    always_ff @(posedge link_sclk or negedge rst_n) begin
        if (!rst_n) begin
            bitcnt_r <= SER_BITCNT_RST;
            shift_r <= '0;
            frame_word_r <= '0;
            frame_tog_r <= 1'b0;
        end else begin
            shift_r <= shift_in;
            if (frame_done) begin
                bitcnt_r <= SER_BITCNT_RST;
                frame_word_r <= shift_in;
                frame_tog_r <= ~frame_tog_r;
            end else begin
                bitcnt_r <= bit_inc;
            end
        end
    end

    // Read data is taken from core registers that only change a few core
    // cycles after a frame ends, long before the next address byte is done.
    wire logic [6:0] rd_addr = shift_r[6:0];
    wire logic rd_req = shift_r[7];
    wire logic [7:0] rd_byte = !rd_req ? 8'h00 :
        (rd_addr == SER_ADDR_ERROR_FLAGS) ? flags_r :
        (rd_addr == SER_ADDR_BURST) ? {7'h00, burst_r} : 8'h00;
    wire logic load_tx = !fresh_r && (bitcnt_r == SER_ADDR_BITS_DONE);
    wire link_rst_n = rst_n & ~cs_n;

    always_ff @(negedge link_sclk or negedge link_rst_n) begin
        if (!link_rst_n) begin
            tx_r <= 8'h00;
            sdo_r <= 1'b0;
            sdo_oe_r <= 1'b0;
        end else begin
            sdo_oe_r <= 1'b1;
            if (load_tx) begin
                tx_r <= {rd_byte[6:0], 1'b0};
                sdo_r <= rd_byte[7];
            end else begin
                tx_r <= {tx_r[6:0], 1'b0};
                sdo_r <= tx_r[7];
            end
        end
    end

    assign sdo = sdo_r;
    assign sdo_oe = sdo_oe_r;

    // ---------------- Core domain ----------------

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cs_s1_r <= 1'b1;
            cs_s2_r <= 1'b1;
            cs_q_r <= 1'b1;
            tog_s1_r <= 1'b0;
            tog_s2_r <= 1'b0;
            tog_q_r <= 1'b0;
        end else begin
            cs_s1_r <= cs_n;
            cs_s2_r <= cs_s1_r;
            cs_q_r <= cs_s2_r;
            tog_s1_r <= frame_tog_r;
            tog_s2_r <= tog_s1_r;
            tog_q_r <= tog_s2_r;
        end
    end

    wire logic frame_evt = tog_s2_r ^ tog_q_r;
    wire logic cs_rise = cs_s2_r & ~cs_q_r;
    wire logic cs_fall = ~cs_s2_r & cs_q_r;

    // Decode of the completed frame; the word is held still for many core cycles.
    wire logic [15:0] cmd_raw = err_en.crc ? frame_word_r[23:8] : frame_word_r[15:0];
    wire ser_cmd_s cmd = cmd_raw;
    wire logic crc_bad = err_en.crc && (crc8(cmd_raw) != frame_word_r[7:0]);
    wire logic is_clear = (cmd_raw == SER_CLEAR_CMD);
    wire logic addr_ok = (cmd.addr == SER_ADDR_SW_DATA) || (cmd.addr == SER_ADDR_ERR_CONFIG) ||
        (cmd.addr == SER_ADDR_ERROR_FLAGS) || (cmd.addr == SER_ADDR_BURST) ||
        (cmd.addr == SER_ADDR_SOFT_RESET);
    wire logic wr_ro = !cmd.rd && (cmd.addr == SER_ADDR_ERROR_FLAGS);
    wire logic good_evt = frame_evt && !crc_bad;
    wire logic wr_evt = good_evt && !cmd.rd && !is_clear;
    wire logic set_crc = frame_evt && crc_bad && !cmd.rd && err_en.crc;
    wire logic set_rw = good_evt && err_en.rw && !is_clear && (!addr_ok || wr_ro);
    wire logic do_clear = good_evt && is_clear;

    // Clock count: whole frames only, exactly one unless burst mode is on.
    wire logic [2:0] frames_sum = {1'b0, frames_r} + {2'b00, frame_evt};
    wire logic count_bad = (bitcnt_r != SER_BITCNT_RST) || (frames_sum == 3'h0) ||
        (!burst_r && (frames_sum > 3'h1));
    wire logic set_sclk = cs_rise && err_en.sclk && count_bad;

    // Software reset key.
    wire logic key_wr = wr_evt && addr_ok && (cmd.addr == SER_ADDR_SOFT_RESET);
    wire logic key_fire = key_wr && (key_r == SER_KEY_ARMED) && (cmd.data == SER_KEY_SECOND);

    always_comb begin
        key_nxt = key_r;
        case (key_r)
            SER_KEY_IDLE: begin
                if (key_wr && cmd.data == SER_KEY_FIRST) begin
                    key_nxt = SER_KEY_ARMED;
                end
            end
            SER_KEY_ARMED: begin
                if (key_wr && cmd.data == SER_KEY_FIRST) begin
                    key_nxt = SER_KEY_ARMED;
                end else if (good_evt && !cmd.rd) begin
                    // The clear command is a write too, so it abandons a half-entered key.
                    key_nxt = SER_KEY_IDLE;
                end
            end
            default: begin
                key_nxt = SER_KEY_IDLE;
            end
        endcase
    end

    // A flag raised in the same cycle as a clear stays set.
    always_comb begin
        flags_nxt = (do_clear || key_fire) ? SER_ERROR_FLAGS_RST : flags_r;
        flags_nxt[SER_FLAG_CRC_BIT] = flags_nxt[SER_FLAG_CRC_BIT] | set_crc;
        flags_nxt[SER_FLAG_SCLK_BIT] = flags_nxt[SER_FLAG_SCLK_BIT] | set_sclk;
        flags_nxt[SER_FLAG_RW_BIT] = flags_nxt[SER_FLAG_RW_BIT] | set_rw;
        flags_nxt[7:3] = 5'h00;
        burst_nxt = burst_r;
        if (wr_evt && cmd.addr == SER_ADDR_BURST) begin
            burst_nxt = cmd.data[SER_BURST_BIT];
        end
        if (key_fire) begin
            burst_nxt = SER_BURST_RST;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            frames_r <= 2'h0;
        end else if (cs_fall || cs_rise) begin
            frames_r <= 2'h0;
        end else if (frame_evt && frames_r != 2'h3) begin
            frames_r <= frames_r + 2'h1;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flags_r <= SER_ERROR_FLAGS_RST;
            burst_r <= SER_BURST_RST;
            key_r <= SER_KEY_IDLE;
            soft_rst_r <= 1'b0;
        end else begin
            flags_r <= flags_nxt;
            burst_r <= burst_nxt;
            key_r <= key_nxt;
            soft_rst_r <= key_fire;
        end
    end

    assign error_flags = flags_r;
    assign burst_en = burst_r;
    assign soft_rst = soft_rst_r;

endmodule

// File: sim/ser_host_model.sv
`timescale 1ns/1ps
module ser_host_model (
    output logic link_sclk,
    output logic cs_n,
    output logic mosi,
    input wire logic sdo
);
    initial begin
        link_sclk = 1'b0;
        cs_n = 1'b1;
        mosi = 1'b0;
    end
    // The clock is left low after each frame and released data shows its inverse, so nothing stale looks valid.
    task automatic xfer(input logic [47:0] bits, input int n, output logic [7:0] rx);
        rx = 8'h00;
        #13 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            mosi = bits[n-1-i];
            #80 link_sclk = 1'b1;
            if (i > 7 && i < 16) rx = {rx[6:0], sdo};
            #80 link_sclk = 1'b0;
        end
        #80 cs_n = 1'b1;
        mosi = ~mosi;
    endtask
    // A changed check enable crosses on link edges, so two are given with select high.
    task automatic idle_clk;
        repeat (2) begin
            #80 link_sclk = 1'b1;
            #80 link_sclk = 1'b0;
        end
    endtask
endmodule

// File: sim/ser_regs_sva.sv
`timescale 1ns/1ps
module ser_regs_sva
    import ser_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst_n,
    input wire logic cs_n,
    input wire logic sdo_oe,
    input wire ser_pkg::ser_err_en_s err_en,
    input wire logic [7:0] error_flags,
    input wire logic burst_en,
    input wire logic soft_rst
);
    default clocking @(posedge core_clk);
    endclocking
    default disable iff (!rst_n);
    flags_upper_a: assert property (error_flags[7:3] == 5'h00) else $error("flag upper bits set");
    soft_pulse_a: assert property (soft_rst |=> !soft_rst) else $error("soft reset too long");
    soft_clear_a: assert property (soft_rst |=> error_flags == 8'h00 && !burst_en)
        else $error("soft reset left state");
    link_quiet_a: assert property (cs_n [*8] |-> $stable(error_flags) && $stable(burst_en) && !soft_rst)
        else $error("state changed while idle");
    rw_gate_a: assert property ($rose(error_flags[2]) |-> err_en.rw) else $error("address flag while off");
    sclk_gate_a: assert property ($rose(error_flags[1]) |-> err_en.sclk) else $error("count flag while off");
    crc_gate_a: assert property ($rose(error_flags[0]) |-> err_en.crc) else $error("crc flag while off");
    oe_idle_a: assert property (cs_n [*2] |-> !sdo_oe) else $error("sdo driven while idle");
endmodule
bind ser_regs ser_regs_sva u_sva (.core_clk(core_clk), .rst_n(rst_n), .cs_n(cs_n), .sdo_oe(sdo_oe),
    .err_en(err_en), .error_flags(error_flags), .burst_en(burst_en), .soft_rst(soft_rst));

// File: sim/testbench.sv
`timescale 1ns/1ps
module testbench;
    import ser_pkg::*;
    logic core_clk, rst_n, link_sclk, cs_n, mosi, sdo, sdo_oe, burst_en, soft_rst;
    logic [7:0] error_flags, rx;
    logic [31:0] rnd;
    ser_err_en_s err_en;
    int error_cnt = 0, check_count = 0, seed = 78, soft_seen = 0;
    int flg = 0, bst = 0, armed = 0, resets = 0;
    ser_regs u_dut (.core_clk(core_clk), .rst_n(rst_n), .link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi),
        .sdo(sdo), .sdo_oe(sdo_oe), .err_en(err_en), .error_flags(error_flags), .burst_en(burst_en),
        .soft_rst(soft_rst));
    ser_host_model u_host (.link_sclk(link_sclk), .cs_n(cs_n), .mosi(mosi), .sdo(sdo));
    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end
    always @(posedge core_clk) if (soft_rst === 1'b1) soft_seen++;
    task automatic chk(input logic [7:0] got, input int exp);
        check_count++;
        if (got !== exp[7:0]) begin
            error_cnt++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp[7:0]);
        end
    endtask
    function automatic logic [7:0] crc8(input logic [15:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 15; i >= 0; i--) c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        return c;
    endfunction
    task automatic run(input logic [15:0] c, input int good = 1);
        int valid, rd;
        rd = (c[14:8] == 7'h03) ? flg : (c[14:8] == 7'h05) ? bst : 0;
        if (err_en.crc) u_host.xfer({24'h0, c, crc8(c) ^ {7'h0, good == 0}}, 24, rx);
        else u_host.xfer({32'h0, c}, 16, rx);
        repeat (10) @(posedge core_clk);
        if (c[15]) chk(rx, rd);
        valid = c[14:8] inside {7'h01, 7'h02, 7'h03, 7'h05, 7'h0b};
        if (err_en.crc && good == 0) flg |= c[15] ? 0 : 1;
        else if (c[15]) flg |= (!valid && err_en.rw) ? 4 : 0;
        else if (c == SER_CLEAR_CMD) begin
            flg = 0;
            armed = 0;
        end else begin
            if (c[14:8] == 7'h05) bst = c[0];
            if (!valid || c[14:8] == 7'h03) flg |= err_en.rw ? 4 : 0;
            if (c[14:8] == 7'h0b && c[7:0] == 8'h05 && armed) begin
                flg = 0;
                bst = 0;
                resets++;
            end
            armed = (c[14:8] == 7'h0b && c[7:0] == 8'ha3);
        end
        chk(error_flags, flg);
        chk({7'h0, burst_en}, bst);
        chk(soft_seen[7:0], resets);
    endtask
    task automatic burst_frame(input int n);
        u_host.xfer({16'h0, 16'h0155, 16'h01aa}, n, rx);
        repeat (10) @(posedge core_clk);
    endtask
    task automatic set_en(input logic rw, input logic sclk, input logic crc);
        @(posedge core_clk);
        err_en <= '{rw: rw, sclk: sclk, crc: crc};
        u_host.idle_clk();
    endtask
    task automatic wrap_up;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        #1000000;
        error_cnt++;
        wrap_up();
    end
    initial begin
        rst_n = 1'b0;
        err_en = '{rw: 1'b1, sclk: 1'b1, crc: 1'b0};
        repeat (8) @(posedge core_clk);
        rst_n <= 1'b1;
        repeat (4) @(posedge core_clk);
        run(16'h8300);
        run(16'h8500);
        run(16'h0501);
        run(16'h8500);
        burst_frame(32);
        run(16'h8300);
        run(16'h0500);
        burst_frame(32);
        flg |= 2;
        run(16'h8400);
        run(SER_CLEAR_CMD);
        run(16'h0300);
        run(16'h7f00);
        run(SER_CLEAR_CMD);
        burst_frame(15);
        flg |= 2;
        run(SER_CLEAR_CMD);
        set_en(1'b0, 1'b0, 1'b0);
        run(16'h8400);
        burst_frame(15);
        repeat (4) begin
            rnd = $random(seed);
            run({8'h01, rnd[7:0]});
        end
        set_en(1'b1, 1'b1, 1'b1);
        run(16'h0501);
        run(16'h0500, 0);
        run(16'h0300);
        run(SER_CLEAR_CMD, 0);
        run(SER_CLEAR_CMD);
        set_en(1'b1, 1'b1, 1'b0);
        run(16'h0ba3);
        run(16'h0100);
        run(16'h0b05);
        run(16'h0300);
        run(16'h0ba3);
        run(16'h0b05);
        wrap_up();
    end
endmodule
